// ---- src/flc_fll_ratio_config.sv ----
// Configuration registers and active settings for two frequency-locked loops
// Summary of operation
// - Both selectors accept master clocks, bit clock, frame clock or other loop
// - Main and sync pre-dividers divide by 1, 2, 4 or 8
// - Output equals oscillator over post-divider; only divisions 2 through 7
// - Post-divider coded as binary value of the division
// - Oscillator is divided reference times three times N.K times ratio
// - Main feedback ratio division equals four-bit code plus one
// - Integer, numerator, denominator are unsigned integers with unit LSB
// - While enabled, integer and numerator wait for update strobe
// - While disabled, integer and numerator writes apply at once
// - Sync ratio divides 1,2,4,8,16 with coding unlike main ratio
// - Sync path shares oscillator; multiplier uses sync ratio and reference
// - Sync integer, numerator, denominator are unit-LSB unsigned integers
// - Sync selector four-bit code; unlisted codes reserved
// - Sync gain is two to the code, saturating at 256
`timescale 1ns/1ps
`default_nettype none
module flc_fll_ratio_config #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]            s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]            s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // Loop settings
    output flc_pkg::flc_cfg_t                 loop_cfg     [flc_pkg::NUM_LOOPS],
    output flc_pkg::flc_nk_t                  loop_nk      [flc_pkg::NUM_LOOPS],
    output flc_pkg::flc_derived_t             loop_derived [flc_pkg::NUM_LOOPS]
);
    import flc_pkg::*;

    // Loop decode assumes two loops in one 8-bit window; STATUS packs the integer
    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must be at least 8");
    end
    if (NUM_LOOPS != 2) begin : g_loop_check
        $error("NUM_LOOPS must be 2");
    end
    if (FIELD_W > 16) begin : g_field_check
        $error("FIELD_W must not exceed 16");
    end

    ////////////////////////////////////////////////////////////////////////
    // State

    flc_cfg_t cfg_reg     [NUM_LOOPS];
    flc_cfg_t cfg_next    [NUM_LOOPS];
    flc_nk_t  shadow_reg  [NUM_LOOPS];
    flc_nk_t  shadow_next [NUM_LOOPS];
    flc_nk_t  active_reg  [NUM_LOOPS];
    flc_nk_t  active_next [NUM_LOOPS];
    logic     pend_reg    [NUM_LOOPS];
    logic     pend_next   [NUM_LOOPS];

    logic              aw_held_reg, aw_held_next;
    logic              w_held_reg, w_held_next;
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [31:0]       wdata_reg, wdata_next;
    logic [3:0]        wstrb_reg, wstrb_next;
    logic              bvalid_reg, bvalid_next;
    logic [1:0]        bresp_reg, bresp_next;
    logic              rvalid_reg, rvalid_next;
    logic [1:0]        rresp_reg, rresp_next;
    logic [31:0]       rdata_reg, rdata_next;

    logic do_write;
    logic [31:0] wr_merge;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_val;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshakes: address and data taken in either order

    // Readies drop while a response waits, so only one write is under way
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

    function automatic logic [31:0] read_reg(input int l, input logic [7:0] ofs);
        logic [31:0] v;
        v = '0;
        unique case (ofs)
            OFS_CTRL: begin
                v[CTRL_ENA_BIT]  = cfg_reg[l].loop_enable;
                v[CTRL_SENA_BIT] = cfg_reg[l].sync_path_enable;
            end
            OFS_REF: begin
                v[REF_MSEL_LSB +: 4] = cfg_reg[l].main_ref_select;
                v[REF_SSEL_LSB +: 4] = cfg_reg[l].sync_ref_select;
                v[REF_MDIV_LSB +: 2] = cfg_reg[l].main_ref_prediv;
                v[REF_SDIV_LSB +: 2] = cfg_reg[l].sync_ref_prediv;
                v[REF_FR_LSB +: 4]   = cfg_reg[l].main_feedback_ratio;
                v[REF_GAIN_LSB +: 4] = cfg_reg[l].main_loop_gain;
                v[REF_OUT_LSB +: 3]  = cfg_reg[l].post_divider;
            end
            OFS_INT:      v[FIELD_W-1:0] = shadow_reg[l].integer_multiplier;
            OFS_NUM:      v[FIELD_W-1:0] = shadow_reg[l].frac_numerator;
            OFS_DEN:      v[FIELD_W-1:0] = cfg_reg[l].frac_denominator;
            OFS_SYNC_CFG: begin
                v[SC_FR_LSB +: 4]   = cfg_reg[l].sync_feedback_ratio;
                v[SC_GAIN_LSB +: 4] = cfg_reg[l].sync_loop_gain;
                v[SC_BW_BIT]        = cfg_reg[l].sync_bandwidth_select;
            end
            OFS_SYNC_INT: v[FIELD_W-1:0] = cfg_reg[l].sync_integer_multiplier;
            OFS_SYNC_NUM: v[FIELD_W-1:0] = cfg_reg[l].sync_frac_numerator;
            OFS_SYNC_DEN: v[FIELD_W-1:0] = cfg_reg[l].sync_frac_denominator;
            OFS_STATUS: begin
                v[0]              = pend_reg[l];
                v[FIELD_W +: FIELD_W] = active_reg[l].integer_multiplier;
            end
            default: v = '0;
        endcase
        return v;
    endfunction

    function automatic logic valid_ofs(input logic [7:0] ofs);
        return (ofs[1:0] == 2'h0) && (ofs <= OFS_STATUS);
    endfunction

    // Legal selector codes; reserved codes are refused
    function automatic logic src_ok(input logic [3:0] c);
        return (c == SRC_MCLK_A) || (c == SRC_MCLK_B) || (c == SRC_LOOP_1) || (c == SRC_LOOP_2)
            || (c >= SRC_BCLK_1 && c <= SRC_BCLK_3) || (c >= SRC_FCLK_1 && c <= SRC_FCLK_3);
    endfunction

    always_comb begin
        int li;
        logic [7:0] wofs;
        li = 0;
        wofs = '0;
        do_write = (aw_held_reg || s_axi_awvalid) && (w_held_reg || s_axi_wvalid) && !bvalid_reg;
        awaddr_next = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_reg;
        wdata_next  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_reg;
        wstrb_next  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_reg;
        aw_held_next = (aw_held_reg || (s_axi_awvalid && s_axi_awready)) && !do_write;
        w_held_next  = (w_held_reg || (s_axi_wvalid && s_axi_wready)) && !do_write;
        wofs = awaddr_next[7:0] - ((awaddr_next[7:0] >= LOOP_STRIDE) ? LOOP_STRIDE : 8'h00);
        li = (awaddr_next[7:0] >= LOOP_STRIDE) ? 1 : 0;
        wr_hit = valid_ofs(wofs) && (awaddr_next[7:0] < 8'(2 * LOOP_STRIDE))
              && (awaddr_next[ADDR_W-1:0] >> 8) == '0 && wofs != OFS_STATUS;
        // Byte lanes left out of the strobe keep their current value
        wr_merge = read_reg(li, wofs);
        for (int b = 0; b < 4; b++) begin
            if (wstrb_next[b]) begin
                wr_merge[8*b +: 8] = wdata_next[8*b +: 8];
            end
        end
        bvalid_next = (bvalid_reg && !s_axi_bready) || do_write;
        bresp_next  = do_write ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_reg;

        // Register writes and shadow handling
        for (int l = 0; l < NUM_LOOPS; l++) begin
            cfg_next[l]    = cfg_reg[l];
            shadow_next[l] = shadow_reg[l];
            active_next[l] = active_reg[l];
            pend_next[l]   = pend_reg[l];
            if (do_write && wr_hit && li == l) begin
                unique case (wofs)
                    OFS_CTRL: begin
                        cfg_next[l].loop_enable      = wr_merge[CTRL_ENA_BIT];
                        cfg_next[l].sync_path_enable = wr_merge[CTRL_SENA_BIT];
                        if (wstrb_next[0] && wdata_next[CTRL_UPD_BIT]) begin
                            active_next[l] = shadow_reg[l];
                            pend_next[l]   = 1'b0;
                        end
                    end
                    OFS_REF: begin
                        if (src_ok(wr_merge[REF_MSEL_LSB +: 4])) begin
                            cfg_next[l].main_ref_select = wr_merge[REF_MSEL_LSB +: 4];
                        end
                        if (src_ok(wr_merge[REF_SSEL_LSB +: 4])) begin
                            cfg_next[l].sync_ref_select = wr_merge[REF_SSEL_LSB +: 4];
                        end
                        cfg_next[l].main_ref_prediv     = wr_merge[REF_MDIV_LSB +: 2];
                        cfg_next[l].sync_ref_prediv     = wr_merge[REF_SDIV_LSB +: 2];
                        cfg_next[l].main_feedback_ratio = wr_merge[REF_FR_LSB +: 4];
                        cfg_next[l].main_loop_gain      = wr_merge[REF_GAIN_LSB +: 4];
                        // Out-of-range divisions are ignored, keeping the old value
                        if (wr_merge[REF_OUT_LSB +: 3] >= POSTDIV_MIN) begin
                            cfg_next[l].post_divider = wr_merge[REF_OUT_LSB +: 3];
                        end
                    end
                    OFS_INT: begin
                        shadow_next[l].integer_multiplier = wr_merge[FIELD_W-1:0];
                    end
                    OFS_NUM: begin
                        shadow_next[l].frac_numerator = wr_merge[FIELD_W-1:0];
                    end
                    OFS_DEN:      cfg_next[l].frac_denominator = wr_merge[FIELD_W-1:0];
                    OFS_SYNC_CFG: begin
                        cfg_next[l].sync_feedback_ratio   = wr_merge[SC_FR_LSB +: 4];
                        cfg_next[l].sync_loop_gain        = wr_merge[SC_GAIN_LSB +: 4];
                        cfg_next[l].sync_bandwidth_select = wr_merge[SC_BW_BIT];
                    end
                    OFS_SYNC_INT: cfg_next[l].sync_integer_multiplier = wr_merge[FIELD_W-1:0];
                    OFS_SYNC_NUM: cfg_next[l].sync_frac_numerator     = wr_merge[FIELD_W-1:0];
                    OFS_SYNC_DEN: cfg_next[l].sync_frac_denominator   = wr_merge[FIELD_W-1:0];
                    default: ;
                endcase
                // Pending shows in STATUS until the strobe lands
                if ((wofs == OFS_INT || wofs == OFS_NUM) && cfg_reg[l].loop_enable) begin
                    pend_next[l] = 1'b1;
                end
            end
            // Disabled loop follows the shadow directly
            if (!cfg_next[l].loop_enable && !(do_write && wr_hit && li == l && wofs == OFS_CTRL
                                             && cfg_reg[l].loop_enable)) begin
                active_next[l] = shadow_next[l];
                pend_next[l]   = 1'b0;
            end
        end

    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    always_comb begin
        logic [7:0] ofs;
        ofs = s_axi_araddr[7:0] - ((s_axi_araddr[7:0] >= LOOP_STRIDE) ? LOOP_STRIDE : 8'h00);
        rd_hit = valid_ofs(ofs) && (s_axi_araddr[7:0] < 8'(2 * LOOP_STRIDE))
              && (s_axi_araddr[ADDR_W-1:0] >> 8) == '0;
        rd_val = read_reg((s_axi_araddr[7:0] >= LOOP_STRIDE) ? 1 : 0, ofs);
        rvalid_next = (rvalid_reg && !s_axi_rready) || (s_axi_arvalid && s_axi_arready);
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (s_axi_arvalid && s_axi_arready) begin
            rdata_next = rd_hit ? rd_val : 32'h0000_0000;
            rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Registered answer stands unchanged until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else begin
            rvalid_reg <= rvalid_next;
            rresp_reg  <= rresp_next;
            rdata_reg  <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loop settings registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int l = 0; l < NUM_LOOPS; l++) begin
                cfg_reg[l]    <= '{main_ref_select: RST_SRC, sync_ref_select: RST_SRC,
                                   post_divider: RST_POSTDIV, sync_bandwidth_select: RST_SYNC_BW,
                                   frac_denominator: RST_DEN, sync_frac_denominator: RST_DEN,
                                   default: '0};
                shadow_reg[l] <= '{RST_FIELD, RST_FIELD};
                active_reg[l] <= '{RST_FIELD, RST_FIELD};
                pend_reg[l]   <= 1'b0;
            end
        end else begin
            cfg_reg     <= cfg_next;
            shadow_reg  <= shadow_next;
            active_reg  <= active_next;
            pend_reg    <= pend_next;
        end
    end

    // Write holding registers: address and data may arrive on different edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg  <= w_held_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded divisions for the analog side

    always_comb begin
        for (int l = 0; l < NUM_LOOPS; l++) begin
            loop_cfg[l] = cfg_reg[l];
            loop_nk[l]  = active_reg[l];
            loop_derived[l].main_ratio_div  = {1'b0, cfg_reg[l].main_feedback_ratio} + 5'h01;
            // Sync ratio uses a power-of-two code, unlike the main ratio
            loop_derived[l].sync_ratio_div  = (cfg_reg[l].sync_feedback_ratio > 4'h4) ? 5'h10
                : 5'(5'h01 << cfg_reg[l].sync_feedback_ratio[2:0]);
            loop_derived[l].main_prediv_div = 4'(4'h1 << cfg_reg[l].main_ref_prediv);
            loop_derived[l].sync_prediv_div = 4'(4'h1 << cfg_reg[l].sync_ref_prediv);
            loop_derived[l].post_div        = cfg_reg[l].post_divider;
            loop_derived[l].sync_gain_val   = (cfg_reg[l].sync_loop_gain >= SGAIN_SAT) ? SGAIN_MAXV
                : 9'(9'h001 << cfg_reg[l].sync_loop_gain[2:0]);
        end
    end
endmodule
`default_nettype wire

// ---- src/flc_pkg.sv ----
// Package: register map, field layouts and codes for the loop configuration block
package flc_pkg;
    localparam int NUM_LOOPS = 2;

    // Register byte offsets, per loop stride
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_REF      = 8'h04;
    localparam logic [7:0] OFS_INT      = 8'h08;
    localparam logic [7:0] OFS_NUM      = 8'h0C;
    localparam logic [7:0] OFS_DEN      = 8'h10;
    localparam logic [7:0] OFS_SYNC_CFG = 8'h14;
    localparam logic [7:0] OFS_SYNC_INT = 8'h18;
    localparam logic [7:0] OFS_SYNC_NUM = 8'h1C;
    localparam logic [7:0] OFS_SYNC_DEN = 8'h20;
    localparam logic [7:0] OFS_STATUS   = 8'h24;
    localparam logic [7:0] LOOP_STRIDE  = 8'h40;

    // CTRL fields
    localparam int CTRL_ENA_BIT  = 0;
    localparam int CTRL_SENA_BIT = 1;
    localparam int CTRL_UPD_BIT  = 2;
    // REF fields
    localparam int REF_MSEL_LSB = 0;
    localparam int REF_SSEL_LSB = 4;
    localparam int REF_MDIV_LSB = 8;
    localparam int REF_SDIV_LSB = 10;
    localparam int REF_FR_LSB   = 12;
    localparam int REF_GAIN_LSB = 16;
    localparam int REF_OUT_LSB  = 20;
    // SYNC_CFG fields
    localparam int SC_FR_LSB   = 0;
    localparam int SC_GAIN_LSB = 4;
    localparam int SC_BW_BIT   = 8;

    localparam int FIELD_W = 16;

    // Source selector codes
    localparam logic [3:0] SRC_MCLK_A  = 4'h0;
    localparam logic [3:0] SRC_MCLK_B  = 4'h1;
    localparam logic [3:0] SRC_LOOP_1  = 4'h4;
    localparam logic [3:0] SRC_LOOP_2  = 4'h5;
    localparam logic [3:0] SRC_BCLK_1  = 4'h8;
    localparam logic [3:0] SRC_BCLK_3  = 4'hA;
    localparam logic [3:0] SRC_FCLK_1  = 4'hC;
    localparam logic [3:0] SRC_FCLK_3  = 4'hE;

    localparam logic [2:0] POSTDIV_MIN = 3'h2;
    localparam logic [2:0] POSTDIV_MAX = 3'h7;
    localparam logic [3:0] SGAIN_SAT   = 4'h8;
    localparam logic [8:0] SGAIN_MAXV  = 9'h100;

    // Reset values
    localparam logic [2:0]  RST_POSTDIV = 3'h2;
    localparam logic [3:0]  RST_SRC     = 4'h0;
    localparam logic        RST_SYNC_BW = 1'b1;
    localparam logic [15:0] RST_FIELD   = 16'h0000;
    localparam logic [15:0] RST_DEN     = 16'h0001;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0]         main_ref_select;
        logic [3:0]         sync_ref_select;
        logic [1:0]         main_ref_prediv;
        logic [1:0]         sync_ref_prediv;
        logic [3:0]         main_feedback_ratio;
        logic [3:0]         main_loop_gain;
        logic [2:0]         post_divider;
        logic [3:0]         sync_feedback_ratio;
        logic [3:0]         sync_loop_gain;
        logic               sync_bandwidth_select;
        logic [FIELD_W-1:0] frac_denominator;
        logic [FIELD_W-1:0] sync_integer_multiplier;
        logic [FIELD_W-1:0] sync_frac_numerator;
        logic [FIELD_W-1:0] sync_frac_denominator;
        logic               loop_enable;
        logic               sync_path_enable;
    } flc_cfg_t;

    typedef struct packed {
        logic [FIELD_W-1:0] integer_multiplier;
        logic [FIELD_W-1:0] frac_numerator;
    } flc_nk_t;

    typedef struct packed {
        logic [4:0] main_ratio_div;   // Division 1..16
        logic [4:0] sync_ratio_div;   // Division 1,2,4,8,16
        logic [3:0] main_prediv_div;  // Division 1,2,4,8
        logic [3:0] sync_prediv_div;
        logic [2:0] post_div;         // Division 2..7
        logic [8:0] sync_gain_val;    // Gain 1..256
    } flc_derived_t;
endpackage

// ---- testbench/flc_fll_ratio_config_props.sv ----
// Checker: bus busy rules and decoded loop settings
`timescale 1ns/1ps
`default_nettype none
module flc_fll_ratio_config_props
    import flc_pkg::*;
(
    // Clock and reset
    input wire logic                  aclk,
    input wire logic                  aresetn,
    // Bus handshakes
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    // Loop settings
    input wire flc_pkg::flc_cfg_t     loop_cfg     [flc_pkg::NUM_LOOPS],
    input wire flc_pkg::flc_nk_t      loop_nk      [flc_pkg::NUM_LOOPS],
    input wire flc_pkg::flc_derived_t loop_derived [flc_pkg::NUM_LOOPS]
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken while busy");
    rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    ratio_code_a: assert property (
        loop_derived[0].main_ratio_div == {1'b0, loop_cfg[0].main_feedback_ratio} + 5'h1)
        else $error("main ratio decode");
    prediv_code_a: assert property (
        loop_derived[0].main_prediv_div == 4'h1 << loop_cfg[0].main_ref_prediv) else $error("prediv decode");
    postdiv_range_a: assert property (
        loop_cfg[0].post_divider inside {[3'h2:3'h7]} ##0 loop_derived[0].post_div == loop_cfg[0].post_divider)
        else $error("post divider range");
    sync_gain_a: assert property (
        loop_derived[0].sync_gain_val == (loop_cfg[0].sync_loop_gain >= SGAIN_SAT ? SGAIN_MAXV
        : 9'h1 << loop_cfg[0].sync_loop_gain)) else $error("sync gain decode");
    sync_ratio_a: assert property (
        loop_cfg[0].sync_feedback_ratio <= 4'h4 |-> loop_derived[0].sync_ratio_div
        == 5'h1 << loop_cfg[0].sync_feedback_ratio) else $error("sync ratio decode");
    sync_sel_a: assert property (
        loop_cfg[0].sync_ref_select inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE})
        else $error("reserved sync selector");
    // Active values may move only on a write response while running
    hold_active_a: assert property (
        !$stable(loop_nk[0]) && $past(loop_cfg[0].loop_enable) |-> $rose(s_axi_bvalid))
        else $error("active values moved without strobe");
endmodule
`default_nettype wire

// ---- testbench/test_fll_ratio_config.sv ----
// Testbench: register accesses and loop setting checks
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module test_fll_ratio_config;
    import flc_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, k, prev;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    flc_cfg_t loop_cfg [NUM_LOOPS];
    flc_nk_t loop_nk [NUM_LOOPS];
    flc_derived_t loop_derived [NUM_LOOPS];
    int miscompares, samples_checked;
    flc_fll_ratio_config #(.ADDR_W(8)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .loop_cfg(loop_cfg), .loop_nk(loop_nk),
        .loop_derived(loop_derived));
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        fork
            begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
            begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(negedge aclk);
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata; rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(negedge aclk);
    endtask
    task automatic close_out();
        if (miscompares == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(OFS_REF); `CHK("ref reset", 32'h0020_0000, rd);
        rdr(OFS_DEN); `CHK("den reset", 32'h0000_0001, rd);
        rdr(OFS_SYNC_CFG); `CHK("sync cfg reset", 32'h0000_0100, rd);
        for (int c = 0; c < 16; c++) begin
            k = 4'(c);
            wr(OFS_REF, {9'h0, 3'(2 + c % 6), k, k, k[3:2], k[1:0], 8'h00});
            `CHK("ratio div", 5'(c + 1), loop_derived[0].main_ratio_div);
            `CHK("post div", 3'(2 + c % 6), loop_derived[0].post_div);
            `CHK("prediv", 4'h1 << k[1:0], loop_derived[0].main_prediv_div);
            `CHK("sync prediv", 4'h1 << k[3:2], loop_derived[0].sync_prediv_div);
            wr(OFS_SYNC_CFG, {24'h0, k, k});
            `CHK("sync gain", (c >= 8) ? 9'h100 : 9'h1 << k, loop_derived[0].sync_gain_val);
            if (c <= 4) `CHK("sync ratio", 5'h1 << k, loop_derived[0].sync_ratio_div)
            else `CHK("sync ratio sat", 5'h10, loop_derived[0].sync_ratio_div);
        end
        wr(OFS_REF, 32'h0010_0000); `CHK("post div kept", 3'h5, loop_cfg[0].post_divider);
        prev = 4'h0;
        for (int c = 0; c < 16; c++) begin
            k = 4'(c);
            if (k inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE}) prev = k;
            wr(OFS_REF, {24'h0, k, k});
            `CHK("sync select", prev, loop_cfg[0].sync_ref_select);
            `CHK("main select", prev, loop_cfg[0].main_ref_select);
        end
        wr(8'h30, 32'h1); `CHK("unmapped wr", RESP_SLVERR, rsp);
        rdr(8'h30); `CHK("unmapped rd", RESP_SLVERR, rsp);
        wr(OFS_STATUS, 32'h1); `CHK("status wr", RESP_SLVERR, rsp);
        wr(OFS_REF, 32'h0024_0000); `CHK("main gain", 4'h4, loop_cfg[0].main_loop_gain);
        wr(OFS_INT, 32'h8); wr(OFS_NUM, 32'h18); wr(OFS_DEN, 32'h7D);
        repeat (2) @(negedge aclk);
        `CHK("int direct", 16'h8, loop_nk[0].integer_multiplier);
        `CHK("num direct", 16'h18, loop_nk[0].frac_numerator);
        `CHK("den", 16'h7D, loop_cfg[0].frac_denominator);
        wr(OFS_CTRL, 32'h1); wr(OFS_INT, 32'h9); wr(OFS_NUM, 32'h30);
        repeat (2) @(negedge aclk);
        `CHK("int held", 16'h8, loop_nk[0].integer_multiplier);
        `CHK("num held", 16'h18, loop_nk[0].frac_numerator);
        rdr(OFS_INT); `CHK("int shadow", 32'h9, rd);
        rdr(OFS_STATUS); `CHK("status pending", 32'h0008_0001, rd);
        wr(OFS_CTRL, 32'h5);
        `CHK("int strobe", 16'h9, loop_nk[0].integer_multiplier);
        `CHK("num strobe", 16'h30, loop_nk[0].frac_numerator);
        rdr(OFS_STATUS); `CHK("status applied", 32'h0009_0000, rd);
        wr(LOOP_STRIDE + OFS_SYNC_INT, 32'h7);
        `CHK("loop2 sync int", 16'h7, loop_cfg[1].sync_integer_multiplier);
        `CHK("loop1 sync int", 16'h0, loop_cfg[0].sync_integer_multiplier);
        close_out();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        close_out();
    end
endmodule
bind flc_fll_ratio_config flc_fll_ratio_config_props chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .loop_cfg(loop_cfg), .loop_nk(loop_nk), .loop_derived(loop_derived));
`default_nettype wire
